// >>> src/pst_pkg.sv
// Types shared by the sequencing supervisor
package pst_pkg;
  typedef enum logic [2:0] {
    ST_OFF   = 3'h0,
    ST_DELAY = 3'h1,
    ST_SEQ   = 3'h3,
    ST_ON    = 3'h2,
    ST_RESET = 3'h6,
    ST_RETRY = 3'h7,
    ST_DSLP  = 3'h5,
    ST_SLEEP = 3'h4
  } pst_state_t;
endpackage

// >>> src/pst_regs.svh
// Register map, field positions, reset values and timing figures
`ifndef PST_REGS_SVH
`define PST_REGS_SVH
`define PST_CLK_HZ        25000000
`define PST_MS_PER_S      1000
`define PST_I2C_TO_S      8
`define PST_HRST_MS       500
`define PST_RETRY_MS      100
`define PST_REG_CNT       6
`define PST_ADDR_W        12
`define PST_OFS_CTRL      12'h000
`define PST_OFS_TURN_ON_DELAY_CODE     12'h004
`define PST_OFS_STAT      12'h008
`define PST_CTRL_SLEEP    0
`define PST_CTRL_HRST     1
`define PST_CTRL_OVSEL    2
`define PST_CTRL_PGTO     4
`define PST_CTRL_SEQ      8
`define PST_CTRL_RST      32'h0000_0004
`define PST_CTRL_MASK     32'h0000_0f35
`define PST_TURN_ON_DELAY_CODE_MASK    32'h0003_ffff
`define PST_STAT_REGEN    8
`define PST_STAT_TO       16
`define PST_STAT_RETRY    17
`define PST_STAT_PIN      18
`define PST_PGTO_0_MS     20
`define PST_PGTO_1_MS     40
`define PST_PGTO_2_MS     60
`define PST_PGTO_3_MS     100
`define PST_TURN_ON_DELAY_CODE_0_MS    0
`define PST_TURN_ON_DELAY_CODE_1_MS    1
`define PST_TURN_ON_DELAY_CODE_2_MS    2
`define PST_TURN_ON_DELAY_CODE_3_MS    4
`define PST_TURN_ON_DELAY_CODE_4_MS    8
`define PST_TURN_ON_DELAY_CODE_5_MS    16
`define PST_TURN_ON_DELAY_CODE_6_MS    32
`define PST_TURN_ON_DELAY_CODE_7_MS    64
`endif

// >>> src/pst_seq_supervisor.sv
// Power sequencing and timing supervisor with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "pst_regs.svh"
module pst_seq_supervisor #(
  parameter int unsigned MS_CYCLES = `PST_CLK_HZ / `PST_MS_PER_S,
  parameter int unsigned I2C_TO_MS = `PST_I2C_TO_S * `PST_MS_PER_S,
  parameter int unsigned HRST_MS   = `PST_HRST_MS
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [`PST_ADDR_W-1:0]    paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      analog_supply_uv_ok,
  input  wire logic                      analog_supply_ov,
  input  wire logic                      power_enable_pin,
  input  wire logic                      i2c_activity,
  input  wire logic [`PST_REG_CNT-1:0]   reg_pg,
  output logic      [`PST_REG_CNT-1:0]   reg_en,
  output logic                           internal_5v_rail_en,
  output logic                           ldo_en,
  output pst_pkg::pst_state_t            seq_state
);
  import pst_pkg::*;

  localparam logic [2:0] LAST_REG = 3'(`PST_REG_CNT - 1);

  pst_state_t        state_q, state_d;
  logic [31:0]       ctrl_q;
  logic [31:0]       turn_on_delay_code_q;
  logic              to_flag_q, retry_flag_q;
  logic [14:0]       tick_cnt_q;
  logic              tick_q;
  logic [15:0]       tmr_q;
  logic [15:0]       i2c_cnt_q;
  logic [2:0]        idx_q;
  logic              wait_pg_q;
  logic              pin_q;
  logic              step;
  logic              restart;
  logic [2:0]        code_w [`PST_REG_CNT];

  // Returns one-hot hit: [0] ctrl, [1] turn_on_delay_code, [2] status
  function automatic logic [2:0] decode(input logic [`PST_ADDR_W-1:0] a);
    decode = {a == `PST_OFS_STAT, a == `PST_OFS_TURN_ON_DELAY_CODE, a == `PST_OFS_CTRL};
  endfunction

  function automatic logic [15:0] turn_on_delay_code_ms(input logic [2:0] c);
    unique case (c)
      3'h0: turn_on_delay_code_ms = 16'(`PST_TURN_ON_DELAY_CODE_0_MS);
      3'h1: turn_on_delay_code_ms = 16'(`PST_TURN_ON_DELAY_CODE_1_MS);
      3'h2: turn_on_delay_code_ms = 16'(`PST_TURN_ON_DELAY_CODE_2_MS);
      3'h3: turn_on_delay_code_ms = 16'(`PST_TURN_ON_DELAY_CODE_3_MS);
      3'h4: turn_on_delay_code_ms = 16'(`PST_TURN_ON_DELAY_CODE_4_MS);
      3'h5: turn_on_delay_code_ms = 16'(`PST_TURN_ON_DELAY_CODE_5_MS);
      3'h6: turn_on_delay_code_ms = 16'(`PST_TURN_ON_DELAY_CODE_6_MS);
      3'h7: turn_on_delay_code_ms = 16'(`PST_TURN_ON_DELAY_CODE_7_MS);
    endcase
  endfunction

  function automatic logic [15:0] pgto_ms(input logic [1:0] s);
    unique case (s)
      2'h0: pgto_ms = 16'(`PST_PGTO_0_MS);
      2'h1: pgto_ms = 16'(`PST_PGTO_1_MS);
      2'h2: pgto_ms = 16'(`PST_PGTO_2_MS);
      2'h3: pgto_ms = 16'(`PST_PGTO_3_MS);
    endcase
  endfunction

  for (genvar g = 0; g < `PST_REG_CNT; g++) begin : g_code
    assign code_w[g] = turn_on_delay_code_q[3*g +: 3];
  end

  // APB handshake: zero wait states, answer in the first access cycle
  logic       setup;
  logic       wr;
  logic [2:0] hit;
  assign setup = psel & ~penable;
  assign wr    = psel & penable & pwrite & pready;
  assign hit   = decode(paddr);

  logic hrst_req;
  assign hrst_req = wr & hit[0] & pwdata[`PST_CTRL_HRST];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~|hit;
      if (setup) begin
        prdata <= 32'h0000_0000;
        if (!pwrite) begin
          unique case (1'b1)
            hit[0]:  prdata <= ctrl_q;
            hit[1]:  prdata <= turn_on_delay_code_q;
            hit[2]:  prdata <= {13'h0000, pin_q, retry_flag_q, to_flag_q,
                                2'h0, reg_en, 5'h00, state_q};
            default: prdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // Hard reset bit is a write strobe and never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= `PST_CTRL_RST;
      turn_on_delay_code_q <= 32'h0000_0000;
    end else if (wr) begin
      if (hit[0]) ctrl_q  <= pwdata & `PST_CTRL_MASK;
      if (hit[1]) turn_on_delay_code_q <= pwdata & `PST_TURN_ON_DELAY_CODE_MASK;
    end
  end

  // Millisecond time base
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 15'h0000;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= tick_cnt_q == 15'(MS_CYCLES - 1);
      tick_cnt_q <= (tick_cnt_q == 15'(MS_CYCLES - 1)) ? 15'h0000 : tick_cnt_q + 15'h0001;
    end
  end

  // Bus inactivity; a timeout set wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i2c_cnt_q <= 16'h0000;
      to_flag_q <= 1'b0;
    end else begin
      if (i2c_activity)
        i2c_cnt_q <= 16'h0000;
      else if (tick_q && i2c_cnt_q != 16'(I2C_TO_MS))
        i2c_cnt_q <= i2c_cnt_q + 16'h0001;
      if (!i2c_activity && tick_q && i2c_cnt_q == 16'(I2C_TO_MS - 1))
        to_flag_q <= 1'b1;
      else if (wr && hit[2] && pwdata[`PST_STAT_TO])
        to_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) retry_flag_q <= 1'b0;
    else if (state_d == ST_RETRY && state_q != ST_RETRY) retry_flag_q <= 1'b1;
    else if (wr && hit[2] && pwdata[`PST_STAT_RETRY]) retry_flag_q <= 1'b0;
  end

  logic active;
  assign active = state_q == ST_DELAY || state_q == ST_SEQ || state_q == ST_ON;

  always_comb begin
    state_d = state_q;
    step    = 1'b0;
    if (!analog_supply_uv_ok)
      state_d = ST_OFF;
    else if (analog_supply_ov)
      state_d = ST_RESET;
    else if (hrst_req)
      state_d = ST_RESET;
    else if (active && ctrl_q[`PST_CTRL_SLEEP])
      state_d = ST_SLEEP;
    else if (active && !power_enable_pin)
      state_d = ST_DSLP;
    else begin
      unique case (state_q)
        ST_OFF: begin
          if (ctrl_q[`PST_CTRL_SLEEP]) state_d = ST_SLEEP;
          else if (!power_enable_pin) state_d = ST_DSLP;
          else state_d = ST_DELAY;
        end
        ST_DSLP:  if (power_enable_pin && !pin_q) state_d = ST_DELAY;
        ST_SLEEP: if (!ctrl_q[`PST_CTRL_SLEEP]) state_d = ST_DELAY;
        ST_DELAY: if (tmr_q >= 16'(ctrl_q[`PST_CTRL_SEQ +: 4])) state_d = ST_SEQ;
        ST_SEQ: begin
          if (!wait_pg_q) begin
            if (tmr_q >= turn_on_delay_code_ms(code_w[idx_q])) step = 1'b1;
          end else if (reg_pg[idx_q]) begin
            step = 1'b1;
            if (idx_q == LAST_REG) state_d = ST_ON;
          end else if (tmr_q >= pgto_ms(ctrl_q[`PST_CTRL_PGTO +: 2])) begin
            state_d = ST_RETRY;
          end
        end
        ST_ON:    state_d = ST_ON;
        ST_RESET: if (tmr_q >= 16'(HRST_MS)) state_d = ST_OFF;
        ST_RETRY: if (tmr_q >= 16'(`PST_RETRY_MS)) state_d = ST_OFF;
      endcase
    end
  end

  // Overvoltage keeps the reset timer from running out
  assign restart = (state_d != state_q) | step | analog_supply_ov;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_OFF;
      tmr_q   <= 16'h0000;
      pin_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      pin_q   <= power_enable_pin;
      if (restart) tmr_q <= 16'h0000;
      else if (tick_q && tmr_q != 16'hffff) tmr_q <= tmr_q + 16'h0001;
    end
  end

  // Regulator walk: delay, enable, then wait for power good
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_q     <= 3'h0;
      wait_pg_q <= 1'b0;
      reg_en    <= '0;
    end else if (state_d != ST_SEQ && state_d != ST_ON) begin
      idx_q     <= 3'h0;
      wait_pg_q <= 1'b0;
      reg_en    <= '0;
    end else if (step) begin
      if (!wait_pg_q) begin
        reg_en[idx_q] <= 1'b1;
        wait_pg_q     <= 1'b1;
      end else begin
        wait_pg_q <= 1'b0;
        if (idx_q != LAST_REG) idx_q <= idx_q + 3'h1;
      end
    end
  end

  // Housekeeping supply stays up through an input overvoltage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      internal_5v_rail_en <= 1'b1;
      ldo_en              <= 1'b0;
    end else begin
      internal_5v_rail_en <= !(analog_supply_ov && !ctrl_q[`PST_CTRL_OVSEL]);
      ldo_en              <= analog_supply_ov && !ctrl_q[`PST_CTRL_OVSEL];
    end
  end

  assign seq_state = state_q;

endmodule // pst_seq_supervisor
`default_nettype wire

// >>> testbench/pst_reg_bank.sv
// Regulator bank model answering enables with power-good
`timescale 1ns/1ps
`default_nettype none
module pst_reg_bank (
  input  wire logic       clk,
  input  wire logic [5:0] en,
  input  wire logic [5:0] fail,
  output logic      [5:0] pg
);
  logic [5:0] en_q;
  // Two-cycle soft start; a failed rail never reports good
  always_ff @(posedge clk) begin
    en_q <= en;
    pg   <= en_q & en & ~fail;
  end
endmodule // pst_reg_bank
`default_nettype wire

// >>> testbench/pst_seq_supervisor_assertions.sv
// Port checker for the sequencing supervisor
`timescale 1ns/1ps
`default_nettype none
module pst_seq_chk
  import pst_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       analog_supply_uv_ok,
  input wire logic       analog_supply_ov,
  input wire logic [5:0] reg_en,
  input wire logic       internal_5v_rail_en,
  input wire logic       ldo_en,
  input wire pst_state_t seq_state
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_ready_a: assert property (psel && !penable |=> pready) else $error("pready late");
  ov_reset_a: assert property (analog_supply_uv_ok && analog_supply_ov |=> seq_state == ST_RESET)
    else $error("no reset on ov");
  uv_off_a: assert property (!analog_supply_uv_ok |=> seq_state == ST_OFF && reg_en == '0)
    else $error("not off on uv");
  reset_off_a: assert property (seq_state == ST_RESET |-> reg_en == '0) else $error("on in reset");
  retry_off_a: assert property (seq_state == ST_RETRY |-> reg_en == '0) else $error("on in retry");
  rail_keep_a: assert property (internal_5v_rail_en != ldo_en) else $error("rail lost");
  ldo_cause_a: assert property (ldo_en |-> $past(analog_supply_ov)) else $error("ldo without ov");
  en_grow_a: assert property ((reg_en & ~$past(reg_en)) != '0 |-> $past(seq_state) == ST_SEQ)
    else $error("enable outside seq");
endmodule // pst_seq_chk
bind pst_seq_supervisor pst_seq_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .analog_supply_uv_ok(analog_supply_uv_ok), .analog_supply_ov(analog_supply_ov),
  .reg_en(reg_en), .internal_5v_rail_en(internal_5v_rail_en), .ldo_en(ldo_en), .seq_state(seq_state));
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the sequencing supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pst_pkg::*;
  localparam int MS = 10;
  logic        pclk, presetn, psel, penable, pwrite, pready, perr, uv, ov, pin, act, r5v, ldo, ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, v, rs;
  logic [5:0]  en, pg, fail;
  pst_state_t  st;
  int          error_cnt = 0, checks = 0, cyc, d;
  pst_seq_supervisor #(.MS_CYCLES(MS), .I2C_TO_MS(20), .HRST_MS(10)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(perr), .analog_supply_uv_ok(uv), .analog_supply_ov(ov), .power_enable_pin(pin),
    .i2c_activity(act), .reg_pg(pg), .reg_en(en), .internal_5v_rail_en(r5v), .ldo_en(ldo), .seq_state(st));
  pst_reg_bank u_bank (.clk(pclk), .en(en), .fail(fail), .pg(pg));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Two waits of one ms granularity each
  task automatic chk_t(input string nm, input int ms);
    checks++;
    if (cyc < (ms - 2) * MS || cyc > (ms + 2) * MS + 8) begin
      error_cnt++;
      $display("mismatch %s expected %0d ms seen %0d cycles", nm, ms, cyc);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dt);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    ev = perr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wst(input pst_state_t s, input bit stay);
    cyc = 0;
    while ((st === s) == stay && cyc < 4000) begin
      @(posedge pclk);
      cyc++;
    end
  endtask
  task automatic wen();
    cyc = 0;
    while (en[0] !== 1'b1 && cyc < 4000) begin
      @(posedge pclk);
      cyc++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    rs = 32'h4a189ca6;
    {psel, penable, pwrite, ov, fail, paddr, pwdata} = '0;
    {uv, pin, act, presetn} = 4'he;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    wen();
    chk_t("power-up", 0);
    apb(0, 12'h000, 0);
    chk("ctrl", 32'h4, rdv);
    apb(0, 12'hffc, 0);
    chk("unmapped", 32'h1, {31'h0, ev});
    for (int c = 0; c < 8; c++) begin
      apb(1, 12'h000, 32'h5);
      wst(ST_SLEEP, 1'b0);
      d = int'(rnd() % 16);
      v = (rnd() & 32'h3fff8) | c;
      apb(1, 12'h004, v);
      apb(1, 12'h000, 32'h4 | (d << 8));
      wen();
      chk_t("sleep exit", d + (c == 0 ? 0 : 1 << (c - 1)));
    end
    $display("turn-on delays done");
    apb(1, 12'h004, 0);
    apb(1, 12'h000, 32'h4);
    wst(ST_ON, 1'b0);
    pin <= 1'b0;
    wst(ST_DSLP, 1'b0);
    pin <= 1'b1;
    wen();
    chk_t("pin exit", 0);
    for (int k = 0; k < 4; k++) begin
      apb(1, 12'h000, 32'h5 | (k << 4));
      wst(ST_SLEEP, 1'b0);
      fail <= 6'h01;
      apb(1, 12'h000, 32'h4 | (k << 4));
      wen();
      wst(ST_RETRY, 1'b0);
      chk_t("pg wait", k == 3 ? 100 : 20 * (k + 1));
      fail <= 6'h00;
      wst(ST_RETRY, 1'b1);
      chk_t("retry", 100);
    end
    apb(0, 12'h008, 0);
    chk("retry flag", 32'h1, rdv[17]);
    wst(ST_ON, 1'b0);
    apb(1, 12'h000, 32'h6);
    wst(ST_RESET, 1'b0);
    wst(ST_RESET, 1'b1);
    chk_t("hard reset", 10);
    for (int s = 0; s < 2; s++) begin
      apb(1, 12'h000, s << 2);
      ov <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("ov state", ST_RESET, st);
      chk("rail", 1 + s, {r5v, ldo});
      ov <= 1'b0;
    end
    wst(ST_ON, 1'b0);
    uv <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("uv state", ST_OFF, st);
    chk("uv enables", 32'h0, en);
    uv <= 1'b1;
    wen();
    chk_t("uv release", 0);
    $display("sequencing done");
    act <= 1'b0;
    repeat (22 * MS) @(posedge pclk);
    apb(0, 12'h008, 0);
    chk("bus timeout", 32'h1, rdv[16]);
    act <= 1'b1;
    apb(1, 12'h008, 32'h1_0000);
    apb(0, 12'h008, 0);
    chk("timeout clear", 32'h0, rdv[16]);
    tally_and_finish();
  end
  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
